// >>> agc_consts.vh
`ifndef AGC_CONSTS_VH
`define AGC_CONSTS_VH

// ----------------------------------------
// Clock and register addresses
// ----------------------------------------
`define AGC_CLK_HZ 100000000
`define AGC_ADDR_W 6
`define AGC_OFS_PLL_FRAC 6'h1C
`define AGC_OFS_AUD_CTL4 6'h1D
`define AGC_OFS_HND_GAIN 6'h1E

// ----------------------------------------
// Fractional PLL register
// ----------------------------------------
`define AGC_FRAC_MSB 15
`define AGC_FRAC_LSB 2
`define AGC_FRAC_MAX 14'h270F
`define AGC_FRAC_RST 14'h0000

// ----------------------------------------
// Audio control four fields
// ----------------------------------------
`define AGC_BIT_MIC_STPD 15
`define AGC_BIT_DAC_STPD 14
`define AGC_BIT_SIDE_STPD 13
`define AGC_BIT_CELL_STPD 12
`define AGC_BIT_BUZZ_STPD 11
`define AGC_HYS_MSB 10
`define AGC_HYS_LSB 9
`define AGC_HYS_NONE 2'h3
`define AGC_MBHED_MSB 8
`define AGC_MBHED_LSB 7
`define AGC_BIT_MBHND 6
`define AGC_BIT_SHORT 1
`define AGC_CTL4_RST 16'h0000

// ----------------------------------------
// Handset gain fields
// ----------------------------------------
`define AGC_BIT_HND_MUTE 15
`define AGC_PGA_MSB 14
`define AGC_PGA_LSB 8
`define AGC_TGT_MSB 7
`define AGC_TGT_LSB 5
`define AGC_TC_MSB 4
`define AGC_TC_LSB 1
`define AGC_BIT_AGC_EN 0
`define AGC_HND_RST 16'hFF00

// ----------------------------------------
// Soft-step sizes in PGA codes per sample period
// ----------------------------------------
`define AGC_STEP_HALF_DB 7'h01
`define AGC_STEP_BUZZ 7'h06

// ----------------------------------------
// AGC time constants in ms
// ----------------------------------------
`define AGC_ATK0_MS 10'h008
`define AGC_ATK1_MS 10'h00B
`define AGC_ATK2_MS 10'h010
`define AGC_ATK3_MS 10'h014
`define AGC_DCY0_MS 10'h064
`define AGC_DCY1_MS 10'h0C8
`define AGC_DCY2_MS 10'h190
`define AGC_DCY3_MS 10'h1F4

`endif

// >>> agc_ramp.v
`include "agc_consts.vh"

module agc_ramp #(
	parameter [6:0] STEP = 7'h01,
	parameter [6:0] RST_VAL = 7'h00
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Control
	input wire tick_i,
	input wire bypass_i,
	input wire [6:0] target_i,
	// Applied gain
	output reg [6:0] gain_o,
	output wire done_o
);
	wire [7:0] up_sum;
	wire [7:0] dn_dif;

	assign up_sum = {1'b0, gain_o} + {1'b0, STEP};
	assign dn_dif = {1'b0, gain_o} - {1'b0, STEP};
	assign done_o = (gain_o == target_i);

	always @(posedge clock_i) begin
		if (rst_i) begin
			gain_o <= RST_VAL;
		end else if (bypass_i) begin
			gain_o <= target_i;
		end else if (tick_i && !done_o) begin
			// Clamp so a coarse step never overshoots the target
			if (gain_o < target_i) begin
				if (up_sum[7] || (up_sum[6:0] > target_i))
					gain_o <= target_i;
				else
					gain_o <= up_sum[6:0];
			end else begin
				if (dn_dif[7] || (dn_dif[6:0] < target_i))
					gain_o <= target_i;
				else
					gain_o <= dn_dif[6:0];
			end
		end
	end
endmodule

// >>> agc_timer.v
module agc_timer (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Period in clock cycles
	input wire [31:0] period_i,
	// One-cycle tick per period
	output reg tick_o
);
	reg [31:0] cnt_q;

	always @(posedge clock_i) begin
		if (rst_i) begin
			cnt_q <= 32'h00000000;
			tick_o <= 1'b0;
		end else if (cnt_q + 32'h00000001 >= period_i) begin
			// A shortened period takes effect at once
			cnt_q <= 32'h00000000;
			tick_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h00000001;
			tick_o <= 1'b0;
		end
	end
endmodule

// >>> agc_regs.v
`include "agc_consts.vh"

// Overview of operation
// - Fraction field holds 14 bits; writes above 9999 store 9999.
// - Fraction value drives the PLL only while the PLL is enabled.
// - Bit 15 set disables mic/handset PGA soft-stepping; reset enables.
// - Bit 14 set disables DAC PGA soft-stepping; reset enables.
// - Bit 13 controls sidetone soft-step, 0.5 dB per sample period.
// - Bit 12 controls cell-phone soft-step, 0.5 dB per sample period.
// - Bit 11 controls buzzer soft-step, 3 dB per sample period.
// - Hysteresis field 1/2/4/none dB, only applied when AGC selected.
// - Bit 1 reads the headphone short-circuit detection status.
// - Handset mute bit 15, resets to 1 so input starts muted.
// - 7-bit handset gain, 0.5 dB steps from 0 dB, resets all ones.
// - With AGC on and handset selected, reads return AGC applied gain.
// - AGC read-back is 8-bit signed in 0.5 dB units.
// - 3-bit AGC target selects -5.5 down to -24 dB.
// - Time field: low bits pick attack, high bits pick decay.
// - Attack and decay times hold regardless of sampling frequency.
// - Bit 0 with handset selected hands handset PGA to the AGC; else stored fields rule.
module agc_regs #(
	parameter [31:0] CYC_PER_MS = `AGC_CLK_HZ / 1000
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Register port from the serial interface
	input wire wr_en_i,
	input wire rd_en_i,
	input wire [5:0] addr_i,
	input wire [15:0] wdata_i,
	output reg [15:0] rdata_o,
	// PLL
	input wire pll_enable_i,
	output wire [13:0] pll_fraction_o,
	// Timing and status from the analog side
	input wire fsref_tick_i,
	input wire headphone_short_i,
	input wire handset_selected_i,
	input wire headset_agc_active_i,
	input wire [7:0] agc_gain_i,
	// Gain targets held in other registers
	input wire [6:0] dac_gain_target_i,
	input wire [6:0] sidetone_gain_target_i,
	input wire [6:0] cellphone_gain_target_i,
	input wire [6:0] buzzer_gain_target_i,
	input wire [6:0] mic_gain_target_i,
	// Applied PGA gains
	output wire [6:0] dac_gain_o,
	output wire [6:0] sidetone_gain_o,
	output wire [6:0] cellphone_gain_o,
	output wire [6:0] buzzer_gain_o,
	output wire [6:0] mic_gain_o,
	output wire [4:0] softstep_done_o,
	// Handset ADC PGA
	output wire handset_input_mute_o,
	output wire [7:0] handset_pga_gain_o,
	// AGC controls
	output wire agc_active_o,
	output wire [1:0] agc_hysteresis_o,
	output wire [2:0] handset_agc_target_o,
	output wire agc_attack_tick_o,
	output wire agc_decay_tick_o,
	// Microphone bias selections
	output wire [1:0] micbias_headset_o,
	output wire micbias_handset_o
);
	// ----------------------------------------
	// Reset images of the settings words
	// ----------------------------------------
	// Named copies, since a bare literal cannot be bit-selected
	localparam [15:0] CTL4_RST = `AGC_CTL4_RST;
	localparam [15:0] HND_RST = `AGC_HND_RST;

	// ----------------------------------------
	// Stored register fields
	// ----------------------------------------
	reg [13:0] pll_fraction_value_q;
	reg [13:0] pll_fraction_value_d;
	reg mic_pga_softstep_disable_q;
	reg dac_pga_softstep_disable_q;
	reg sidetone_softstep_disable_q;
	reg cellphone_softstep_disable_q;
	reg buzzer_softstep_disable_q;
	reg [1:0] agc_hysteresis_select_q;
	reg [1:0] micbias_headset_q;
	reg micbias_handset_q;
	reg handset_input_mute_q;
	reg [6:0] handset_pga_gain_q;
	reg [2:0] handset_agc_target_q;
	reg [3:0] handset_agc_time_constant_q;
	reg handset_agc_enable_q;
	reg [15:0] rdata_d;

	wire sel_frac;
	wire sel_ctl4;
	wire sel_hnd;
	wire [13:0] wr_frac;
	wire handset_agc_on;
	wire headphone_short_flag;
	wire [6:0] handset_ramp_gain;

	assign sel_frac = (addr_i == `AGC_OFS_PLL_FRAC);
	assign sel_ctl4 = (addr_i == `AGC_OFS_AUD_CTL4);
	assign sel_hnd = (addr_i == `AGC_OFS_HND_GAIN);
	assign wr_frac = wdata_i[`AGC_FRAC_MSB:`AGC_FRAC_LSB];
	assign handset_agc_on = handset_agc_enable_q & handset_selected_i;
	assign headphone_short_flag = headphone_short_i;

	// ----------------------------------------
	// Fractional PLL multiplier
	// ----------------------------------------
	always @* begin
		// Saturate rather than wrap, so a bad write stays in range
		if (wr_frac > `AGC_FRAC_MAX)
			pll_fraction_value_d = `AGC_FRAC_MAX;
		else
			pll_fraction_value_d = wr_frac;
	end

	always @(posedge clock_i) begin
		if (rst_i) begin
			pll_fraction_value_q <= `AGC_FRAC_RST;
		end else if (wr_en_i && sel_frac) begin
			pll_fraction_value_q <= pll_fraction_value_d;
		end
	end

	assign pll_fraction_o = pll_enable_i ? pll_fraction_value_q : 14'h0000;

	// ----------------------------------------
	// Audio control four
	// ----------------------------------------
	always @(posedge clock_i) begin
		if (rst_i) begin
			mic_pga_softstep_disable_q <= CTL4_RST[`AGC_BIT_MIC_STPD];
			dac_pga_softstep_disable_q <= CTL4_RST[`AGC_BIT_DAC_STPD];
			sidetone_softstep_disable_q <= CTL4_RST[`AGC_BIT_SIDE_STPD];
			cellphone_softstep_disable_q <= CTL4_RST[`AGC_BIT_CELL_STPD];
			buzzer_softstep_disable_q <= CTL4_RST[`AGC_BIT_BUZZ_STPD];
			agc_hysteresis_select_q <= CTL4_RST[`AGC_HYS_MSB:`AGC_HYS_LSB];
			micbias_headset_q <= CTL4_RST[`AGC_MBHED_MSB:`AGC_MBHED_LSB];
			micbias_handset_q <= CTL4_RST[`AGC_BIT_MBHND];
		end else if (wr_en_i && sel_ctl4) begin
			mic_pga_softstep_disable_q <= wdata_i[`AGC_BIT_MIC_STPD];
			dac_pga_softstep_disable_q <= wdata_i[`AGC_BIT_DAC_STPD];
			sidetone_softstep_disable_q <= wdata_i[`AGC_BIT_SIDE_STPD];
			cellphone_softstep_disable_q <= wdata_i[`AGC_BIT_CELL_STPD];
			buzzer_softstep_disable_q <= wdata_i[`AGC_BIT_BUZZ_STPD];
			agc_hysteresis_select_q <= wdata_i[`AGC_HYS_MSB:`AGC_HYS_LSB];
			micbias_headset_q <= wdata_i[`AGC_MBHED_MSB:`AGC_MBHED_LSB];
			micbias_handset_q <= wdata_i[`AGC_BIT_MBHND];
		end
	end

	assign micbias_headset_o = micbias_headset_q;
	assign micbias_handset_o = micbias_handset_q;

	// ----------------------------------------
	// Handset gain and AGC settings
	// ----------------------------------------
	always @(posedge clock_i) begin
		if (rst_i) begin
			handset_input_mute_q <= HND_RST[`AGC_BIT_HND_MUTE];
			handset_pga_gain_q <= HND_RST[`AGC_PGA_MSB:`AGC_PGA_LSB];
			handset_agc_target_q <= HND_RST[`AGC_TGT_MSB:`AGC_TGT_LSB];
			handset_agc_time_constant_q <= HND_RST[`AGC_TC_MSB:`AGC_TC_LSB];
			handset_agc_enable_q <= HND_RST[`AGC_BIT_AGC_EN];
		end else if (wr_en_i && sel_hnd) begin
			handset_input_mute_q <= wdata_i[`AGC_BIT_HND_MUTE];
			handset_pga_gain_q <= wdata_i[`AGC_PGA_MSB:`AGC_PGA_LSB];
			handset_agc_target_q <= wdata_i[`AGC_TGT_MSB:`AGC_TGT_LSB];
			handset_agc_time_constant_q <= wdata_i[`AGC_TC_MSB:`AGC_TC_LSB];
			handset_agc_enable_q <= wdata_i[`AGC_BIT_AGC_EN];
		end
	end

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	always @* begin
		rdata_d = 16'h0000;
		if (sel_frac) begin
			rdata_d[`AGC_FRAC_MSB:`AGC_FRAC_LSB] = pll_fraction_value_q;
		end else if (sel_ctl4) begin
			// Reserved bits stay zero
			rdata_d[`AGC_BIT_MIC_STPD] = mic_pga_softstep_disable_q;
			rdata_d[`AGC_BIT_DAC_STPD] = dac_pga_softstep_disable_q;
			rdata_d[`AGC_BIT_SIDE_STPD] = sidetone_softstep_disable_q;
			rdata_d[`AGC_BIT_CELL_STPD] = cellphone_softstep_disable_q;
			rdata_d[`AGC_BIT_BUZZ_STPD] = buzzer_softstep_disable_q;
			rdata_d[`AGC_HYS_MSB:`AGC_HYS_LSB] = agc_hysteresis_select_q;
			rdata_d[`AGC_MBHED_MSB:`AGC_MBHED_LSB] = micbias_headset_q;
			rdata_d[`AGC_BIT_MBHND] = micbias_handset_q;
			rdata_d[`AGC_BIT_SHORT] = headphone_short_flag;
		end else if (sel_hnd) begin
			if (handset_agc_on)
				rdata_d[`AGC_BIT_HND_MUTE:`AGC_PGA_LSB] = agc_gain_i;
			else
				rdata_d[`AGC_BIT_HND_MUTE:`AGC_PGA_LSB] =
					{handset_input_mute_q, handset_pga_gain_q};
			rdata_d[`AGC_TGT_MSB:`AGC_TGT_LSB] = handset_agc_target_q;
			rdata_d[`AGC_TC_MSB:`AGC_TC_LSB] = handset_agc_time_constant_q;
			rdata_d[`AGC_BIT_AGC_EN] = handset_agc_enable_q;
		end
	end

	always @(posedge clock_i) begin
		if (rst_i)
			rdata_o <= 16'h0000;
		else if (rd_en_i)
			rdata_o <= rdata_d;
	end

	// ----------------------------------------
	// Soft-stepping of PGA gains
	// ----------------------------------------
	agc_ramp #(.STEP(`AGC_STEP_HALF_DB), .RST_VAL(7'h7F)) u_hnd_ramp (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(fsref_tick_i),
		.bypass_i(mic_pga_softstep_disable_q),
		.target_i(handset_pga_gain_q),
		.gain_o(handset_ramp_gain),
		.done_o()
	);

	agc_ramp #(.STEP(`AGC_STEP_HALF_DB), .RST_VAL(7'h00)) u_mic_ramp (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(fsref_tick_i),
		.bypass_i(mic_pga_softstep_disable_q),
		.target_i(mic_gain_target_i),
		.gain_o(mic_gain_o),
		.done_o(softstep_done_o[0])
	);

	agc_ramp #(.STEP(`AGC_STEP_HALF_DB), .RST_VAL(7'h00)) u_dac_ramp (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(fsref_tick_i),
		.bypass_i(dac_pga_softstep_disable_q),
		.target_i(dac_gain_target_i),
		.gain_o(dac_gain_o),
		.done_o(softstep_done_o[1])
	);

	agc_ramp #(.STEP(`AGC_STEP_HALF_DB), .RST_VAL(7'h00)) u_side_ramp (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(fsref_tick_i),
		.bypass_i(sidetone_softstep_disable_q),
		.target_i(sidetone_gain_target_i),
		.gain_o(sidetone_gain_o),
		.done_o(softstep_done_o[2])
	);

	agc_ramp #(.STEP(`AGC_STEP_HALF_DB), .RST_VAL(7'h00)) u_cell_ramp (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(fsref_tick_i),
		.bypass_i(cellphone_softstep_disable_q),
		.target_i(cellphone_gain_target_i),
		.gain_o(cellphone_gain_o),
		.done_o(softstep_done_o[3])
	);

	agc_ramp #(.STEP(`AGC_STEP_BUZZ), .RST_VAL(7'h00)) u_buzz_ramp (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(fsref_tick_i),
		.bypass_i(buzzer_softstep_disable_q),
		.target_i(buzzer_gain_target_i),
		.gain_o(buzzer_gain_o),
		.done_o(softstep_done_o[4])
	);

	// ----------------------------------------
	// Handset PGA control
	// ----------------------------------------
	// AGC owns the PGA, the mute then being part of its signed gain
	assign handset_input_mute_o = handset_agc_on ? 1'b0 : handset_input_mute_q;
	assign handset_pga_gain_o = handset_agc_on ? agc_gain_i
		: {1'b0, handset_ramp_gain};
	assign agc_active_o = handset_agc_on;
	assign handset_agc_target_o = handset_agc_target_q;
	assign agc_hysteresis_o = (handset_agc_on || headset_agc_active_i)
		? agc_hysteresis_select_q : `AGC_HYS_NONE;

	// ----------------------------------------
	// AGC attack and decay timing
	// ----------------------------------------
	// Counted on the fixed system clock, so sample rate does not matter
	reg [9:0] atk_ms;
	reg [9:0] dcy_ms;
	wire [41:0] atk_prod;
	wire [41:0] dcy_prod;

	always @* begin
		case (handset_agc_time_constant_q[1:0])
			2'h0: atk_ms = `AGC_ATK0_MS;
			2'h1: atk_ms = `AGC_ATK1_MS;
			2'h2: atk_ms = `AGC_ATK2_MS;
			default: atk_ms = `AGC_ATK3_MS;
		endcase
		case (handset_agc_time_constant_q[3:2])
			2'h0: dcy_ms = `AGC_DCY0_MS;
			2'h1: dcy_ms = `AGC_DCY1_MS;
			2'h2: dcy_ms = `AGC_DCY2_MS;
			default: dcy_ms = `AGC_DCY3_MS;
		endcase
	end

	assign atk_prod = {32'h00000000, atk_ms} * {10'h000, CYC_PER_MS};
	assign dcy_prod = {32'h00000000, dcy_ms} * {10'h000, CYC_PER_MS};

	agc_timer u_atk_timer (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.period_i(atk_prod[31:0]),
		.tick_o(agc_attack_tick_o)
	);

	agc_timer u_dcy_timer (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.period_i(dcy_prod[31:0]),
		.tick_o(agc_decay_tick_o)
	);
endmodule

// >>> agc_regs_chk.sv
module agc_regs_chk (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Register port
	input wire wr_en_i,
	input wire rd_en_i,
	input wire [5:0] addr_i,
	input wire [15:0] wdata_i,
	input wire [15:0] rdata_o,
	// Status and gains
	input wire pll_enable_i,
	input wire [13:0] pll_fraction_o,
	input wire fsref_tick_i,
	input wire headset_agc_active_i,
	input wire [7:0] agc_gain_i,
	input wire [6:0] dac_gain_target_i,
	input wire [6:0] sidetone_gain_target_i,
	input wire [6:0] cellphone_gain_target_i,
	input wire [6:0] buzzer_gain_target_i,
	input wire [6:0] dac_gain_o,
	input wire [6:0] sidetone_gain_o,
	input wire [6:0] cellphone_gain_o,
	input wire [6:0] buzzer_gain_o,
	input wire [6:0] mic_gain_o,
	input wire agc_active_o,
	input wire [1:0] agc_hysteresis_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// Shadow of soft-step disables
	// ----------------------------------------
	reg [4:0] stpd_q;
	always @(posedge clock_i) begin
		if (rst_i)
			stpd_q <= 5'h00;
		else if (wr_en_i && addr_i == 6'h1D)
			stpd_q <= wdata_i[15:11];
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	frac_sat_a: assert property (
		wr_en_i && addr_i == 6'h1C && wdata_i[15:2] > 14'h270F ##1 pll_enable_i
		|-> pll_fraction_o == 14'h270F) else $error("fraction not saturated");
	pll_off_a: assert property (
		!pll_enable_i |-> pll_fraction_o == 14'h0000) else $error("fraction with pll off");
	frac_rsvd_a: assert property (
		rd_en_i && addr_i == 6'h1C |=> rdata_o[1:0] == 2'h0) else $error("fraction low bits");
	ctl_rsvd_a: assert property (
		rd_en_i && addr_i == 6'h1D |=> rdata_o[5:2] == 4'h0 && !rdata_o[0])
		else $error("control reserved bits");
	agc_read_a: assert property (
		rd_en_i && addr_i == 6'h1E && agc_active_o |=> rdata_o[15:8] == $past(agc_gain_i))
		else $error("agc gain read-back");
	hys_none_a: assert property (
		!agc_active_o && !headset_agc_active_i |-> agc_hysteresis_o == 2'h3)
		else $error("hysteresis without agc");
	side_step_a: assert property (
		!stpd_q[2] && fsref_tick_i && sidetone_gain_o < sidetone_gain_target_i
		|=> sidetone_gain_o == $past(sidetone_gain_o) + 7'h01) else $error("sidetone step");
	cell_step_a: assert property (
		!stpd_q[1] && fsref_tick_i && cellphone_gain_o > cellphone_gain_target_i
		|=> cellphone_gain_o == $past(cellphone_gain_o) - 7'h01) else $error("cell step");
	buzz_step_a: assert property (
		!stpd_q[0] && fsref_tick_i && {1'b0, buzzer_gain_o} + 8'h06 <= {1'b0, buzzer_gain_target_i}
		|=> buzzer_gain_o == $past(buzzer_gain_o) + 7'h06) else $error("buzzer step");
	dac_jump_a: assert property (
		stpd_q[3] |=> dac_gain_o == $past(dac_gain_target_i)) else $error("dac not immediate");
	mic_hold_a: assert property (
		!stpd_q[4] && !fsref_tick_i |=> $stable(mic_gain_o)) else $error("mic moved untimed");
	cover property (!stpd_q[2] && fsref_tick_i && sidetone_gain_o != sidetone_gain_target_i);
	cover property (rd_en_i && addr_i == 6'h1E && agc_active_o);
	cover property (stpd_q[3] && dac_gain_o != dac_gain_target_i);
endmodule

bind agc_regs agc_regs_chk u_chk (
	.clock_i(clock_i), .rst_i(rst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .pll_enable_i(pll_enable_i),
	.pll_fraction_o(pll_fraction_o), .fsref_tick_i(fsref_tick_i),
	.headset_agc_active_i(headset_agc_active_i), .agc_gain_i(agc_gain_i),
	.dac_gain_target_i(dac_gain_target_i), .sidetone_gain_target_i(sidetone_gain_target_i),
	.cellphone_gain_target_i(cellphone_gain_target_i),
	.buzzer_gain_target_i(buzzer_gain_target_i), .dac_gain_o(dac_gain_o),
	.sidetone_gain_o(sidetone_gain_o), .cellphone_gain_o(cellphone_gain_o),
	.buzzer_gain_o(buzzer_gain_o), .mic_gain_o(mic_gain_o), .agc_active_o(agc_active_o),
	.agc_hysteresis_o(agc_hysteresis_o)
);

// >>> test_audio_gain_agc_control.sv
module test_audio_gain_agc_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, we, re, pen, tk, shrt, sel, hagc;
	logic [5:0] ad;
	logic [15:0] wd, d;
	logic [7:0] ag;
	logic [6:0] dt, st, ct, bt, mt;
	wire [15:0] rdat;
	wire [13:0] frac;
	wire [6:0] dg, sg, cg, bg, mg;
	wire [4:0] dn;
	wire [7:0] hg;
	wire [1:0] hy;
	wire [2:0] tg;
	wire mu, act, atk, dcy;
	wire [1:0] mbh;
	wire mbd;
	int n_errors = 0;
	int checks_done = 0;
	int n;
	logic [37:0] rows [10];
	int atk_ms [4] = '{8, 11, 16, 20};
	int dcy_ms [4] = '{100, 200, 400, 500};
	// Short ms keeps the decay waits to a few thousand cycles
	localparam int CYC = 4;

	agc_regs #(.CYC_PER_MS(32'h00000004)) u_dut (
		.clock_i(clk), .rst_i(rst), .wr_en_i(we), .rd_en_i(re), .addr_i(ad), .wdata_i(wd),
		.rdata_o(rdat), .pll_enable_i(pen), .pll_fraction_o(frac), .fsref_tick_i(tk),
		.headphone_short_i(shrt), .handset_selected_i(sel), .headset_agc_active_i(hagc),
		.agc_gain_i(ag), .dac_gain_target_i(dt), .sidetone_gain_target_i(st),
		.cellphone_gain_target_i(ct), .buzzer_gain_target_i(bt), .mic_gain_target_i(mt),
		.dac_gain_o(dg), .sidetone_gain_o(sg), .cellphone_gain_o(cg), .buzzer_gain_o(bg),
		.mic_gain_o(mg), .softstep_done_o(dn), .handset_input_mute_o(mu),
		.handset_pga_gain_o(hg), .agc_active_o(act), .agc_hysteresis_o(hy),
		.handset_agc_target_o(tg), .agc_attack_tick_o(atk), .agc_decay_tick_o(dcy),
		.micbias_headset_o(mbh), .micbias_handset_o(mbd)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [5:0] a, input logic [15:0] v);
		@(negedge clk);
		ad = a;
		wd = v;
		we = 1'b1;
		@(negedge clk);
		we = 1'b0;
	endtask
	task rd(input logic [5:0] a);
		@(negedge clk);
		ad = a;
		re = 1'b1;
		@(negedge clk);
		re = 1'b0;
		d = rdat;
	endtask
	task tick();
		@(negedge clk);
		tk = 1'b1;
		@(negedge clk);
		tk = 1'b0;
	endtask
	task conclude();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Bounded wait; n ends as cycles since the call
	task wait_tick(input bit s);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((s ? dcy : atk) !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			n_errors++;
			conclude();
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst, we, re, pen, tk, shrt, sel, hagc} = 8'hFF & 8'h80;
		{ad, wd, ag, dt, st, ct, bt, mt} = '0;
		rows = '{{6'h1C, 16'h0004, 16'h0004}, {6'h1C, 16'h9C3C, 16'h9C3C},
			{6'h1C, 16'h9C40, 16'h9C3C}, {6'h1C, 16'hFFFF, 16'h9C3C},
			{6'h1C, 16'h0003, 16'h0000}, {6'h1D, 16'hFFFF, 16'hFFC0},
			{6'h1D, 16'h0000, 16'h0000}, {6'h1E, 16'h1234, 16'h1234},
			{6'h1E, 16'hFFFF, 16'hFFFF}, {6'h3F, 16'h5A5A, 16'h0000}};
		repeat (2) @(negedge clk);
		rst = 1'b0;
		rd(6'h1C);
		chk("fraction reset", d, 16'h0000);
		rd(6'h1D);
		chk("control reset", d, 16'h0000);
		rd(6'h1E);
		chk("handset reset", d, 16'hFF00);
		chk("mute out", 16'(mu), 16'h0001);
		chk("handset gain", 16'(hg), 16'h007F);
		$display("reset test done");
		for (int i = 0; i < 10; i++) begin
			wr(rows[i][37:32], rows[i][31:16]);
			rd(rows[i][37:32]);
			chk("table read", d, rows[i][15:0]);
		end
		rd(6'h1E);
		chk("unmapped write", d, 16'hFFFF);
		$display("table test done");
		pen = 1'b1;
		wr(6'h1C, 16'hFFFC);
		chk("pll fraction", 16'(frac), 16'h270F);
		pen = 1'b0;
		@(negedge clk);
		chk("pll off", 16'(frac), 16'h0000);
		shrt = 1'b1;
		rd(6'h1D);
		chk("short flag", d, 16'h0002);
		shrt = 1'b0;
		rd(6'h1D);
		chk("short clear", d, 16'h0000);
		$display("pll and short test done");
		sel = 1'b1;
		ag = 8'h77;
		wr(6'h1E, 16'h00A3);
		rd(6'h1E);
		chk("agc max read", d, 16'h77A3);
		chk("agc active", 16'({act, mu}), 16'h0002);
		ag = 8'hE8;
		rd(6'h1E);
		chk("agc neg read", d, 16'hE8A3);
		chk("agc pga out", 16'(hg), 16'h00E8);
		for (int h = 3; h >= 0; h--) begin
			wr(6'h1D, 16'(h << 9));
			chk("hysteresis", 16'(hy), 16'(h));
		end
		sel = 1'b0;
		rd(6'h1E);
		chk("stored read", d, 16'h00A3);
		chk("no agc hys", 16'(hy), 16'h0003);
		hagc = 1'b1;
		@(negedge clk);
		chk("headset hys", 16'(hy), 16'h0000);
		hagc = 1'b0;
		for (int k = 0; k < 8; k++) begin
			wr(6'h1E, 16'(k << 5));
			chk("agc target", 16'(tg), 16'(k));
		end
		$display("agc test done");
		for (int i = 0; i < 4; i++) begin
			wr(6'h1E, 16'((i * 5) << 1) | 16'h0001);
			wait_tick(1'b0);
			wait_tick(1'b0);
			chk("attack period", 16'(n), 16'(atk_ms[i] * CYC));
			wait_tick(1'b1);
			wait_tick(1'b1);
			chk("decay period", 16'(n), 16'(dcy_ms[i] * CYC));
		end
		$display("timer test done");
		{st, ct, bt, dt, mt} = {7'h05, 7'h03, 7'h0E, 7'h04, 7'h02};
		for (int k = 1; k <= 3; k++) begin
			tick();
			chk("side ramp", 16'(sg), 16'(k));
			chk("cell ramp", 16'(cg), 16'(k));
			chk("buzz ramp", 16'(bg), k == 3 ? 16'h000E : 16'(6 * k));
			chk("dac ramp", 16'(dg), 16'(k));
			chk("mic ramp", 16'(mg), k > 2 ? 16'h0002 : 16'(k));
			chk("hnd ramp", 16'(hg), 16'(7'h7F - k));
		end
		repeat (3) @(negedge clk);
		chk("side hold", 16'(sg), 16'h0003);
		chk("done bits", 16'(dn), 16'h0019);
		wr(6'h1D, 16'hF9C0);
		chk("micbias out", 16'({mbh, mbd}), 16'h0007);
		@(negedge clk);
		chk("jump", {2'h0, sg, dg}, {2'h0, 7'h05, 7'h04});
		chk("hnd jump", 16'(hg), 16'h0000);
		chk("all done", 16'(dn), 16'h001F);
		{st, ct, bt, dt, mt} = {5{7'h40}};
		@(negedge clk);
		chk("jump again", {2'h0, cg, mg}, {2'h0, 7'h40, 7'h40});
		chk("buzz jump", 16'(bg), 16'h0040);
		wr(6'h1D, 16'h0000);
		{st, ct} = {7'h3E, 7'h3E};
		tick();
		chk("down ramp", {2'h0, sg, cg}, {2'h0, 7'h3F, 7'h3F});
		$display("soft-step test done");
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		rd(6'h1D);
		chk("ctl after reset", d, 16'h0000);
		chk("micbias reset", 16'({mbh, mbd}), 16'h0000);
		rd(6'h1E);
		chk("hnd after reset", d, 16'hFF00);
		chk("ramps after reset", {2'h0, sg, hg[6:0]}, {2'h0, 7'h00, 7'h7F});
		$display("mid-run reset test done");
		conclude();
	end
endmodule
